// file: rtl/pioc_consts.svh
// constants for the port i/o pin control block
`ifndef PIOC_CONSTS_SVH
`define PIOC_CONSTS_SVH

`define PIOC_PIN_COUNT     15
`define PIOC_P2_WIDTH      6

`define PIOC_ADDR_PORT0    8'h80
`define PIOC_ADDR_PORT2    8'hA0
`define PIOC_ADDR_PORT3    8'hB0
`define PIOC_ADDR_MODE0    8'hA4
`define PIOC_ADDR_MODE2    8'hA6
`define PIOC_ADDR_MODE3    8'hA7
`define PIOC_ADDR_GCTL     8'hE2

`define PIOC_GCTL_PUD_BIT  7
`define PIOC_GCTL_INEN_BIT 6
`define PIOC_GCTL_CKOE_BIT 0

`define PIOC_PORT_RST      8'hFF
`define PIOC_MODE_RST      8'h00
`define PIOC_GCTL_RST      8'h00

`define PIOC_PIN_CKOUT     0
`define PIOC_PIN_EXTCLK    3
`define PIOC_PIN_TX        4
`define PIOC_PIN_RX        5
`define PIOC_PIN_INT0      2

`endif

// file: rtl/pioc_pkg.sv
// types shared by the port i/o pin control block
`default_nettype none
package pioc_pkg;

  typedef enum logic [2:0] {
    PIOC_REG_NONE  = 3'h0,
    PIOC_REG_PORT0 = 3'h1,
    PIOC_REG_PORT2 = 3'h2,
    PIOC_REG_PORT3 = 3'h3,
    PIOC_REG_MODE0 = 3'h4,
    PIOC_REG_MODE2 = 3'h5,
    PIOC_REG_MODE3 = 3'h6,
    PIOC_REG_GCTL  = 3'h7
  } pioc_reg_type;

endpackage
`default_nettype wire

// file: rtl/pioc_drive.sv
// per-pin driver and weak pullup decode for all port pins
`timescale 1ns/100ps
`default_nettype none
`include "pioc_consts.svh"

module pioc_drive (
  input  wire logic [`PIOC_PIN_COUNT-1:0] drive_i,
  input  wire logic [`PIOC_PIN_COUNT-1:0] latch_i,
  input  wire logic [`PIOC_PIN_COUNT-1:0] mode_i,
  input  wire logic                       pullup_disable_i,
  output logic      [`PIOC_PIN_COUNT-1:0] out_o,
  output logic      [`PIOC_PIN_COUNT-1:0] oe_o,
  output logic      [`PIOC_PIN_COUNT-1:0] pullup_o
);

  always_comb begin
    // open-drain: only the low driver; push-pull: always one driver on
    out_o    = drive_i & mode_i;
    oe_o     = mode_i | ~drive_i;
    // pullup only for an open-drain pin whose latch bit is 1, saves current otherwise
    pullup_o = {`PIOC_PIN_COUNT{~pullup_disable_i}}
               & ~mode_i & latch_i;
  end

endmodule // pioc_drive
`default_nettype wire

// file: rtl/pioc_top.sv
// port i/o pin control: port latches, output modes, pin routing
`timescale 1ns/100ps
`default_nettype none
`include "pioc_consts.svh"

module pioc_top
  import pioc_pkg::*;
(
  input  wire logic                       mclk_i,
  input  wire logic                       rst_n_i,
  input  wire logic [7:0]                 sfr_addr_i,
  input  wire logic                       sfr_wr_i,
  input  wire logic [7:0]                 sfr_wdata_i,
  input  wire logic                       sfr_bit_wr_i,
  input  wire logic [2:0]                 sfr_bit_sel_i,
  input  wire logic                       sfr_bit_val_i,
  input  wire logic                       sfr_rd_i,
  input  wire logic                       sfr_rmw_i,
  output logic      [7:0]                 sfr_rdata_o,
  input  wire logic [`PIOC_PIN_COUNT-1:0] pin_in_i,
  output logic      [`PIOC_PIN_COUNT-1:0] pin_out_o,
  output logic      [`PIOC_PIN_COUNT-1:0] pin_oe_o,
  output logic      [`PIOC_PIN_COUNT-1:0] pin_pullup_o,
  input  wire logic                       uart_tx_i,
  output logic                            uart_rx_o,
  output logic                            external_clock_input_o,
  output logic                            external_interrupt_zero_o
);

  function automatic pioc_reg_type reg_decode(input logic [7:0] addr);
    case (addr)
      `PIOC_ADDR_PORT0: reg_decode = PIOC_REG_PORT0;
      `PIOC_ADDR_PORT2: reg_decode = PIOC_REG_PORT2;
      `PIOC_ADDR_PORT3: reg_decode = PIOC_REG_PORT3;
      `PIOC_ADDR_MODE0: reg_decode = PIOC_REG_MODE0;
      `PIOC_ADDR_MODE2: reg_decode = PIOC_REG_MODE2;
      `PIOC_ADDR_MODE3: reg_decode = PIOC_REG_MODE3;
      `PIOC_ADDR_GCTL:  reg_decode = PIOC_REG_GCTL;
      default:          reg_decode = PIOC_REG_NONE;
    endcase
  endfunction

  // register state
  logic [7:0]               port0_latch_r, port0_latch_nxt;
  logic [5:0]               port2_latch_r, port2_latch_nxt;
  logic                     port3_latch_r, port3_latch_nxt;
  logic [7:0]               port0_mode_r,  port0_mode_nxt;
  logic [5:0]               port2_mode_r,  port2_mode_nxt;
  logic                     port3_mode_r,  port3_mode_nxt;
  logic                     pullup_disable_r, pullup_disable_nxt;
  logic                     global_input_enable_r, global_input_enable_nxt;
  logic                     clock_out_enable_r, clock_out_enable_nxt;
  logic [7:0]               rdata_r, rdata_nxt;
  pioc_reg_type             reg_sel;

  // pin state
  logic [`PIOC_PIN_COUNT-1:0] in_s1_r, in_s2_r;
  logic [`PIOC_PIN_COUNT-1:0] in_s1_nxt, in_s2_nxt;
  logic [`PIOC_PIN_COUNT-1:0] out_r, oe_r, pullup_r;
  logic [`PIOC_PIN_COUNT-1:0] out_nxt, oe_nxt, pullup_nxt;
  logic                       rx_r, extclk_r, int0_r;
  logic                       rx_nxt, extclk_nxt, int0_nxt;
  logic [`PIOC_PIN_COUNT-1:0] latch_v, mode_v, drive_v, pin_v;

  assign latch_v = {port3_latch_r, port2_latch_r, port0_latch_r};
  assign mode_v  = {port3_mode_r, port2_mode_r, port0_mode_r};
  // pins that fail the input enable read as zero
  assign pin_v   = in_s2_r & {`PIOC_PIN_COUNT{global_input_enable_r}};

  always_comb begin
    drive_v = latch_v;
    drive_v[`PIOC_PIN_TX] = latch_v[`PIOC_PIN_TX] & uart_tx_i;
  end

  // register file next state
  always_comb begin
    port0_latch_nxt         = port0_latch_r;
    port2_latch_nxt         = port2_latch_r;
    port3_latch_nxt         = port3_latch_r;
    port0_mode_nxt          = port0_mode_r;
    port2_mode_nxt          = port2_mode_r;
    port3_mode_nxt          = port3_mode_r;
    pullup_disable_nxt      = pullup_disable_r;
    global_input_enable_nxt = global_input_enable_r;
    clock_out_enable_nxt    = clock_out_enable_r;
    rdata_nxt               = rdata_r;
    reg_sel                 = reg_decode(sfr_addr_i);
    if (sfr_wr_i) begin
      case (reg_sel)
        PIOC_REG_PORT0: port0_latch_nxt = sfr_wdata_i;
        PIOC_REG_PORT2: port2_latch_nxt = sfr_wdata_i[5:0];
        PIOC_REG_PORT3: port3_latch_nxt = sfr_wdata_i[0];
        PIOC_REG_MODE0: port0_mode_nxt  = sfr_wdata_i;
        PIOC_REG_MODE2: port2_mode_nxt  = sfr_wdata_i[5:0];
        PIOC_REG_MODE3: port3_mode_nxt  = sfr_wdata_i[0];
        PIOC_REG_GCTL: begin
          pullup_disable_nxt      = sfr_wdata_i[`PIOC_GCTL_PUD_BIT];
          global_input_enable_nxt = sfr_wdata_i[`PIOC_GCTL_INEN_BIT];
          clock_out_enable_nxt    = sfr_wdata_i[`PIOC_GCTL_CKOE_BIT];
        end
        default: ;
      endcase
    end else if (sfr_bit_wr_i) begin
      // bits beyond a port's width are ignored
      case (reg_sel)
        PIOC_REG_PORT0: port0_latch_nxt[sfr_bit_sel_i] = sfr_bit_val_i;
        PIOC_REG_PORT2: begin
          if (sfr_bit_sel_i < 3'h6) begin
            port2_latch_nxt[sfr_bit_sel_i] = sfr_bit_val_i;
          end
        end
        PIOC_REG_PORT3: begin
          if (sfr_bit_sel_i == 3'h0) begin
            port3_latch_nxt = sfr_bit_val_i;
          end
        end
        default: ;
      endcase
    end
    if (sfr_rd_i) begin
      rdata_nxt = 8'h00;
      case (reg_sel)
        PIOC_REG_PORT0: begin
          rdata_nxt = sfr_rmw_i ? port0_latch_r : pin_v[7:0];
        end
        PIOC_REG_PORT2: begin
          rdata_nxt[5:0] = sfr_rmw_i ? port2_latch_r : pin_v[13:8];
        end
        PIOC_REG_PORT3: begin
          rdata_nxt[0] = sfr_rmw_i ? port3_latch_r : pin_v[14];
        end
        PIOC_REG_MODE0: rdata_nxt      = port0_mode_r;
        PIOC_REG_MODE2: rdata_nxt[5:0] = port2_mode_r;
        PIOC_REG_MODE3: rdata_nxt[0]   = port3_mode_r;
        PIOC_REG_GCTL: begin
          rdata_nxt[`PIOC_GCTL_PUD_BIT]  = pullup_disable_r;
          rdata_nxt[`PIOC_GCTL_INEN_BIT] = global_input_enable_r;
          rdata_nxt[`PIOC_GCTL_CKOE_BIT] = clock_out_enable_r;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port0_latch_r         <= `PIOC_PORT_RST;
      port2_latch_r         <= 6'h3F;
      port3_latch_r         <= 1'b1;
      port0_mode_r          <= `PIOC_MODE_RST;
      port2_mode_r          <= 6'h00;
      port3_mode_r          <= 1'b0;
      pullup_disable_r      <= 1'b0;
      global_input_enable_r <= 1'b0;
      clock_out_enable_r    <= 1'b0;
      rdata_r               <= 8'h00;
    end else begin
      port0_latch_r         <= port0_latch_nxt;
      port2_latch_r         <= port2_latch_nxt;
      port3_latch_r         <= port3_latch_nxt;
      port0_mode_r          <= port0_mode_nxt;
      port2_mode_r          <= port2_mode_nxt;
      port3_mode_r          <= port3_mode_nxt;
      pullup_disable_r      <= pullup_disable_nxt;
      global_input_enable_r <= global_input_enable_nxt;
      clock_out_enable_r    <= clock_out_enable_nxt;
      rdata_r               <= rdata_nxt;
    end
  end

  pioc_drive u_drive (
    .drive_i          (drive_v),
    .latch_i          (latch_v),
    .mode_i           (mode_v),
    .pullup_disable_i (pullup_disable_r),
    .out_o            (out_nxt),
    .oe_o             (oe_nxt),
    .pullup_o         (pullup_nxt)
  );

  // pin side next state
  always_comb begin
    in_s1_nxt  = pin_in_i;
    in_s2_nxt  = in_s1_r;
    // the sampled external clock is only good well below mclk/2
    extclk_nxt = pin_v[`PIOC_PIN_EXTCLK];
    rx_nxt     = pin_v[`PIOC_PIN_RX];
    int0_nxt   = pin_v[`PIOC_PIN_INT0];
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_s1_r  <= '0;
      in_s2_r  <= '0;
      out_r    <= '0;
      oe_r     <= '0;
      pullup_r <= '0;
      rx_r     <= 1'b0;
      extclk_r <= 1'b0;
      int0_r   <= 1'b0;
    end else begin
      in_s1_r  <= in_s1_nxt;
      in_s2_r  <= in_s2_nxt;
      out_r    <= out_nxt;
      oe_r     <= oe_nxt;
      pullup_r <= pullup_nxt;
      rx_r     <= rx_nxt;
      extclk_r <= extclk_nxt;
      int0_r   <= int0_nxt;
    end
  end

  // inverted core clock cannot pass a flop, so bit0 is muxed after it
  always_comb begin
    pin_out_o = out_r;
    pin_oe_o  = oe_r;
    if (clock_out_enable_r) begin
      pin_out_o[`PIOC_PIN_CKOUT] = port0_mode_r[0] & ~mclk_i;
      pin_oe_o[`PIOC_PIN_CKOUT]  = port0_mode_r[0] | mclk_i;
    end
  end

  assign pin_pullup_o              = pullup_r;
  assign sfr_rdata_o               = rdata_r;
  assign uart_rx_o                 = rx_r;
  assign external_clock_input_o    = extclk_r;
  assign external_interrupt_zero_o = int0_r;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  open_drain_a: assert property (
    ((oe_r ^ ~$past(drive_v)) & ~$past(mode_v)) == '0
    && (out_r & ~$past(mode_v)) == '0)
    else $error("open-drain driver mismatch");

  push_pull_a: assert property (
    ((~oe_r | (out_r ^ $past(drive_v))) & $past(mode_v)) == '0)
    else $error("push-pull driver mismatch");

  weak_pullup_a: assert property (
    (pullup_r & ($past(mode_v) | ~$past(latch_v))) == '0
    && (!$past(pullup_disable_r) || pullup_r == '0))
    else $error("pullup on when it must be off");

  tx_gate_a: assert property (
    $past(mode_v[`PIOC_PIN_TX]) |->
      out_r[`PIOC_PIN_TX] == ($past(uart_tx_i) & $past(port0_latch_r[4])))
    else $error("tx pin not tx and latch");

  inputs_off_a: assert property (
    !global_input_enable_r |=>
      !uart_rx_o && !external_clock_input_o && !external_interrupt_zero_o)
    else $error("input path open while disabled");

  extclk_route_a: assert property (
    global_input_enable_r [*3] |=>
      external_clock_input_o == $past(pin_in_i[`PIOC_PIN_EXTCLK], 3))
    else $error("external clock not from its pin");

  rx_route_a: assert property (
    global_input_enable_r [*3] |=>
      uart_rx_o == $past(pin_in_i[`PIOC_PIN_RX], 3))
    else $error("uart receive not from its pin");

  read_zero_a: assert property (
    sfr_rd_i && !sfr_rmw_i && !global_input_enable_r
    && sfr_addr_i == `PIOC_ADDR_PORT0 |=> sfr_rdata_o == 8'h00)
    else $error("port read not zero while inputs off");

  rmw_latch_a: assert property (
    sfr_rd_i && sfr_rmw_i && sfr_addr_i == `PIOC_ADDR_PORT0
    |=> sfr_rdata_o == $past(port0_latch_r))
    else $error("modify read did not return latch");

  byte_write_a: assert property (
    sfr_wr_i && sfr_addr_i == `PIOC_ADDR_PORT0
    |=> port0_latch_r == $past(sfr_wdata_i) [*2] or
        (sfr_wr_i || sfr_bit_wr_i))
    else $error("port byte write not held");

  bit_write_a: assert property (
    !sfr_wr_i && sfr_bit_wr_i && sfr_addr_i == `PIOC_ADDR_PORT0
    |=> port0_latch_r[$past(sfr_bit_sel_i)] == $past(sfr_bit_val_i))
    else $error("port bit write not held");

  ctrl_unused_a: assert property (
    sfr_rd_i && sfr_addr_i == `PIOC_ADDR_GCTL |=> sfr_rdata_o[5:1] == 5'h00)
    else $error("control unused bits not zero");

  cover_input_pin_c: cover property (
    global_input_enable_r && !port0_mode_r[1] && port0_latch_r[1]);
  cover_clock_out_c: cover property (
    clock_out_enable_r && port0_mode_r[0]);
  cover_rmw_c: cover property (
    sfr_rd_i && sfr_rmw_i ##1 sfr_bit_wr_i);

endmodule // pioc_top
`default_nettype wire

// file: tb/pioc_pins_model.sv
// external circuitry model: resolves every port pin level
`timescale 1ns/100ps
`default_nettype none
`include "pioc_consts.svh"

module pioc_pins_model (
  input  wire logic                       mclk_i,
  input  wire logic [`PIOC_PIN_COUNT-1:0] pin_out_i,
  input  wire logic [`PIOC_PIN_COUNT-1:0] pin_oe_i,
  input  wire logic [`PIOC_PIN_COUNT-1:0] pin_pullup_i,
  input  wire logic [`PIOC_PIN_COUNT-1:0] ext_en_i,
  input  wire logic [`PIOC_PIN_COUNT-1:0] ext_val_i,
  output logic      [`PIOC_PIN_COUNT-1:0] pin_level_o
);
  logic [`PIOC_PIN_COUNT-1:0] last_r = '0;

  // floating pin with no pullup toggles, so a stale level never passes
  always_comb begin
    for (int i = 0; i < `PIOC_PIN_COUNT; i++) begin
      if (pin_oe_i[i]) begin
        pin_level_o[i] = pin_out_i[i];
      end else if (ext_en_i[i]) begin
        pin_level_o[i] = ext_val_i[i];
      end else if (pin_pullup_i[i]) begin
        pin_level_o[i] = 1'b1;
      end else begin
        pin_level_o[i] = ~last_r[i];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    last_r <= pin_level_o;
  end
endmodule // pioc_pins_model
`default_nettype wire

// file: tb/pioc_top_test.sv
// self-checking bench for the port i/o pin control block
`timescale 1ns/100ps
`default_nettype none
`include "pioc_consts.svh"

module pioc_top_test;
  logic        mclk_i;
  logic        rst_n_i;
  logic [7:0]  sfr_addr_i;
  logic        sfr_wr_i;
  logic [7:0]  sfr_wdata_i;
  logic        sfr_bit_wr_i;
  logic [2:0]  sfr_bit_sel_i;
  logic        sfr_bit_val_i;
  logic        sfr_rd_i;
  logic        sfr_rmw_i;
  logic [7:0]  sfr_rdata_o;
  logic [14:0] pin_in_i;
  logic [14:0] pin_out_o;
  logic [14:0] pin_oe_o;
  logic [14:0] pin_pullup_o;
  logic        uart_tx_i;
  logic        uart_rx_o;
  logic        ext_clk;
  logic        ext_int;
  logic [14:0] ext_en;
  logic [14:0] ext_val;
  logic [7:0]  d;
  int          bad_count;
  int          comparisons;

  pioc_top i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_bit_wr_i(sfr_bit_wr_i),
    .sfr_bit_sel_i(sfr_bit_sel_i), .sfr_bit_val_i(sfr_bit_val_i),
    .sfr_rd_i(sfr_rd_i), .sfr_rmw_i(sfr_rmw_i), .sfr_rdata_o(sfr_rdata_o),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .pin_pullup_o(pin_pullup_o), .uart_tx_i(uart_tx_i),
    .uart_rx_o(uart_rx_o), .external_clock_input_o(ext_clk),
    .external_interrupt_zero_o(ext_int));

  pioc_pins_model i_pins (.mclk_i(mclk_i), .pin_out_i(pin_out_o),
    .pin_oe_i(pin_oe_o), .pin_pullup_i(pin_pullup_o), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pin_level_o(pin_in_i));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask

  task automatic chk(input string name, input logic [14:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr_i = a;
    sfr_wdata_i = v;
    sfr_wr_i = 1'b1;
    step(1);
    sfr_wr_i = 1'b0;
    step(1);
  endtask

  task automatic bw(input logic [7:0] a, input logic [2:0] s, input logic v);
    sfr_addr_i = a;
    sfr_bit_sel_i = s;
    sfr_bit_val_i = v;
    sfr_bit_wr_i = 1'b1;
    step(1);
    sfr_bit_wr_i = 1'b0;
    step(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] v);
    sfr_addr_i = a;
    sfr_rmw_i = m;
    sfr_rd_i = 1'b1;
    step(1);
    v = sfr_rdata_o;
    sfr_rd_i = 1'b0;
    sfr_rmw_i = 1'b0;
    step(1);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // whole run is about 110 cycles; allow ample margin
  initial begin
    #(25 * 3000);
    bad_count++;
    results();
  end

  initial begin
    {sfr_addr_i, sfr_wdata_i, sfr_bit_sel_i} = '0;
    {sfr_wr_i, sfr_bit_wr_i, sfr_bit_val_i, sfr_rd_i, sfr_rmw_i} = '0;
    {ext_en, ext_val} = '0;
    uart_tx_i = 1'b1;
    bad_count = 0;
    comparisons = 0;
    rst_n_i = 1'b0;
    step(10);
    rst_n_i = 1'b1;
    step(1);
    rd(`PIOC_ADDR_GCTL, 1'b0, d); chk("gctl reset", d, 15'h00);
    rd(`PIOC_ADDR_PORT0, 1'b0, d); chk("p0 no inen", d, 15'h00);
    rd(`PIOC_ADDR_PORT0, 1'b1, d); chk("p0 latch", d, 15'hFF);
    rd(`PIOC_ADDR_MODE0, 1'b0, d); chk("mode0 reset", d, 15'h00);
    rd(8'h55, 1'b0, d); chk("unmapped", d, 15'h00);
    chk("oe reset", pin_oe_o, 15'h0000);
    chk("pullup reset", pin_pullup_o, 15'h7FFF);
    $display("test reset done");
    wr(`PIOC_ADDR_GCTL, 8'hFF);
    rd(`PIOC_ADDR_GCTL, 1'b0, d); chk("gctl bits", d, 15'hC1);
    wr(`PIOC_ADDR_GCTL, 8'h40);
    wr(`PIOC_ADDR_PORT0, 8'h0F);
    chk("od oe", pin_oe_o[7:0], 15'hF0);
    chk("od out", pin_out_o[7:0], 15'h00);
    chk("od pullup", pin_pullup_o[7:0], 15'h0F);
    step(3);
    rd(`PIOC_ADDR_PORT0, 1'b0, d); chk("od pins", d, 15'h0F);
    rd(`PIOC_ADDR_PORT0, 1'b1, d); chk("od latch", d, 15'h0F);
    $display("test open drain done");
    wr(`PIOC_ADDR_MODE0, 8'hFF);
    wr(`PIOC_ADDR_PORT0, 8'hA5);
    chk("pp oe", pin_oe_o[7:0], 15'hFF);
    chk("pp out", pin_out_o[7:0], 15'hA5);
    chk("pp pullup", pin_pullup_o[7:0], 15'h00);
    bw(`PIOC_ADDR_PORT0, 3'h4, 1'b1);
    uart_tx_i = 1'b0;
    step(2);
    chk("tx low", pin_out_o[4], 15'h0);
    uart_tx_i = 1'b1;
    step(2);
    chk("tx high", pin_out_o[4], 15'h1);
    $display("test push pull done");
    bw(`PIOC_ADDR_PORT2, 3'h5, 1'b0);
    bw(`PIOC_ADDR_PORT2, 3'h6, 1'b0);
    rd(`PIOC_ADDR_PORT2, 1'b1, d); chk("p2 bits", d, 15'h1F);
    bw(`PIOC_ADDR_MODE0, 3'h0, 1'b0);
    rd(`PIOC_ADDR_MODE0, 1'b0, d); chk("mode bitwr", d, 15'hFF);
    bw(`PIOC_ADDR_PORT3, 3'h0, 1'b0);
    rd(`PIOC_ADDR_PORT3, 1'b1, d); chk("p3 bitwr", d, 15'h00);
    bw(`PIOC_ADDR_PORT3, 3'h0, 1'b1);
    rd(`PIOC_ADDR_PORT3, 1'b1, d); chk("p3 latch", d, 15'h01);
    wr(`PIOC_ADDR_MODE3, 8'hFF);
    rd(`PIOC_ADDR_MODE3, 1'b0, d); chk("mode3", d, 15'h01);
    wr(`PIOC_ADDR_MODE2, 8'h3F);
    chk("p2 p3 oe", pin_oe_o[14:8], 15'h7F);
    chk("p2 out", pin_out_o[13:8], 15'h1F);
    $display("test bits done");
    wr(`PIOC_ADDR_MODE0, 8'h00);
    wr(`PIOC_ADDR_PORT0, 8'hFF);
    wr(`PIOC_ADDR_GCTL, 8'hC0);
    chk("pud", pin_pullup_o[7:0], 15'h00);
    wr(`PIOC_ADDR_GCTL, 8'h40);
    chk("pullup on", pin_pullup_o[7:0], 15'hFF);
    ext_en = 15'h002C;
    ext_val = 15'h002C;
    step(4);
    chk("routes high", {uart_rx_o, ext_clk, ext_int}, 15'h7);
    rd(`PIOC_ADDR_PORT0, 1'b0, d); chk("p0 in", d, 15'hFF);
    rd(`PIOC_ADDR_PORT2, 1'b0, d); chk("p2 in", d, 15'h1F);
    rd(`PIOC_ADDR_PORT3, 1'b0, d); chk("p3 in", d, 15'h01);
    ext_val = 15'h0000;
    step(4);
    chk("routes low", {uart_rx_o, ext_clk, ext_int}, 15'h0);
    rd(`PIOC_ADDR_PORT0, 1'b0, d); chk("p0 in low", d, 15'hD3);
    ext_val = 15'h002C;
    wr(`PIOC_ADDR_GCTL, 8'h00);
    step(4);
    chk("inen off", {uart_rx_o, ext_clk, ext_int}, 15'h0);
    rd(`PIOC_ADDR_PORT0, 1'b0, d); chk("p0 inen off", d, 15'h00);
    ext_en = 15'h0000;
    $display("test inputs done");
    wr(`PIOC_ADDR_MODE0, 8'h01);
    wr(`PIOC_ADDR_GCTL, 8'h41);
    chk("ckout hi", {pin_oe_o[0], pin_out_o[0]}, 15'h2);
    #12.5;
    chk("ckout lo", {pin_oe_o[0], pin_out_o[0]}, 15'h3);
    step(1);
    wr(`PIOC_ADDR_PORT0, 8'hFF);
    wr(`PIOC_ADDR_GCTL, 8'h40);
    // mclk is high here, so a clock still routed would read 0
    chk("ckout off", pin_out_o[0], 15'h1);
    $display("test clock out done");
    results();
  end
endmodule // pioc_top_test
`default_nettype wire
